// >>> rtl/rvi_rgb_ingest.sv
`include "rvi_defs.svh"
`default_nettype none
module rvi_rgb_ingest (
	input  wire logic        i_sys_clk,             // System clock
	input  wire logic        i_rst,                 // Sync reset, high
	input  wire logic        i_dot_clk,             // Link dot clock
	input  wire logic        i_vsync,               // Frame sync pin
	input  wire logic        i_hsync,               // Line sync pin
	input  wire logic        i_enable,              // Data enable pin
	input  wire logic [17:0] i_data,                // Pixel data bus
	input  wire logic        i_vsync_polarity,      // 1 inverts vsync
	input  wire logic        i_hsync_polarity,      // 1 inverts hsync
	input  wire logic        i_enable_polarity,     // 1 inverts enable
	input  wire logic        i_dot_clock_polarity,  // 1 samples on fall
	input  wire logic        i_ram_path_select,     // 1 gives RAM to RGB
	input  wire rvi_pkg::rvi_width_t i_rgb_width_select,  // Port width
	input  wire logic        i_fast_ram_write,      // Fast write on
	input  wire rvi_pkg::rvi_addr_t i_ram_start_address,  // Frame base
	input  wire logic [5:0]  i_driven_line_count,   // Lines/8 minus 1
	input  wire logic [1:0]  i_display_clock_source,  // 01 is RGB mode
	input  wire logic        i_base_image_on,       // Base enable
	input  wire logic        i_partial_one_on,      // Partial 1 enable
	input  wire logic        i_partial_two_on,      // Partial 2 enable
	output logic             o_ram_we,              // RAM write, dot clk
	output rvi_pkg::rvi_addr_t o_ram_addr,          // RAM write address
	output rvi_pkg::rvi_pix_t  o_ram_wdata,         // RAM write data
	output logic             o_gate_pulse,          // Gate scan clock
	output rvi_pkg::rvi_line_t o_gate_line,         // Line being driven
	output logic [8:0]       o_base_row,            // Base RAM row read
	output logic             o_base_show,           // Base image shown
	output logic             o_frame_pulse,         // Frame done, sys clk
	output logic             o_rgb_active,          // Frame in progress
	output logic             o_partial_one_show,    // Partial 1 shown
	output logic             o_partial_two_show,    // Partial 2 shown
	output logic             o_scroll_allow,        // Scroll permitted
	output logic             o_panel_from_dot,      // Timing from dot clk
	output logic             o_width_reserved       // Width code invalid
);
	import rvi_pkg::*;

	////////////////////////////////////////////////////////////////////
	// System-domain configuration

	logic       cfg_pol_reg;    // Dot clock polarity, captured
	logic [2:0] cfg_spol_reg;   // Vsync, hsync, enable polarity
	logic       cfg_path_reg;   // RAM path select
	rvi_width_t cfg_width_reg;  // Width select
	logic       cfg_fast_reg;   // Fast write
	rvi_addr_t  cfg_addr_reg;   // Start address
	logic [5:0] cfg_nl_reg;     // Driven line code
	logic       cfg_rgb_reg;    // External RGB display mode
	logic [2:0] cfg_show_reg;   // Base, partial 1, partial 2

	// Settings only ever enter on the system side
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cfg_pol_reg   <= 1'b0;
			cfg_spol_reg  <= 3'h0;
			cfg_path_reg  <= 1'b0;
			cfg_width_reg <= `RVI_W18;
			cfg_fast_reg  <= 1'b0;
			cfg_addr_reg  <= 17'h00000;
			cfg_nl_reg    <= 6'h00;
			cfg_rgb_reg   <= 1'b0;
			cfg_show_reg  <= 3'h0;
		end else begin
			cfg_pol_reg   <= i_dot_clock_polarity;
			cfg_spol_reg  <= {i_vsync_polarity, i_hsync_polarity,
				i_enable_polarity};
			cfg_path_reg  <= i_ram_path_select;
			cfg_width_reg <= i_rgb_width_select;
			cfg_fast_reg  <= i_fast_ram_write;
			cfg_addr_reg  <= i_ram_start_address;
			cfg_nl_reg    <= i_driven_line_count;
			cfg_rgb_reg   <= i_display_clock_source == `RVI_DCS_RGB;
			cfg_show_reg  <= {i_base_image_on, i_partial_one_on,
				i_partial_two_on};
		end
	end

	// Partial and scroll only outside RGB mode
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_partial_one_show <= 1'b0;
			o_partial_two_show <= 1'b0;
			o_scroll_allow     <= 1'b0;
			o_panel_from_dot   <= 1'b0;
			o_width_reserved   <= 1'b0;
		end else begin
			o_partial_one_show <= cfg_show_reg[1] && !cfg_rgb_reg;
			o_partial_two_show <= cfg_show_reg[0] && !cfg_rgb_reg;
			o_scroll_allow     <= !cfg_rgb_reg;
			o_panel_from_dot   <= cfg_rgb_reg;
			o_width_reserved   <= cfg_width_reg == `RVI_WRES;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link clock: dot clock with selectable sampling edge

	// Polarity is a static setting; changing it mid-frame glitches
	// the link clock, so software sets it before the source starts
	logic dot_clk;  // Effective link clock
	assign dot_clk = i_dot_clk ^ cfg_pol_reg;

	logic       rst_l1_reg;  // Reset into link domain, stage 1
	logic       rst_l_reg;   // Link-domain reset
	// Reset crosses as a level through two flops
	always_ff @(posedge dot_clk) begin
		rst_l1_reg <= i_rst;
		rst_l_reg  <= rst_l1_reg;
	end

	// Quasi-static settings into the link domain
	localparam int CW = 32;
	logic [CW-1:0] cfg_sys;   // Bundle on the system side
	logic [CW-1:0] cfg_link;  // Bundle on the link side
	assign cfg_sys = {cfg_spol_reg, cfg_path_reg, cfg_width_reg,
		cfg_fast_reg, cfg_addr_reg, cfg_nl_reg, cfg_rgb_reg,
		cfg_show_reg[2]};

	rvi_sync2 #(
		.WIDTH (CW)
	) u_cfg_sync (
		.i_clk (dot_clk),
		.i_d   (cfg_sys),
		.o_q   (cfg_link)
	);

	logic [2:0] l_spol;   // Sync and enable polarity, link side
	logic       l_path;   // RAM path select, link side
	rvi_width_t l_width;  // Width select, link side
	logic       l_fast;   // Fast write, link side
	rvi_addr_t  l_addr;   // Start address, link side
	logic [5:0] l_nl;     // Line code, link side
	logic       l_rgb;    // RGB mode, link side
	logic       l_base;   // Base image enable, link side
	assign {l_spol, l_path, l_width, l_fast, l_addr, l_nl, l_rgb,
		l_base} = cfg_link;

	////////////////////////////////////////////////////////////////////
	// Pin sampling; syncs and data are source-synchronous to dot clock

	logic        vs_reg;    // Vsync, active high internally
	logic        vs_d_reg;  // Previous vsync
	logic        hs_reg;    // Hsync, active high internally
	logic        hs_d_reg;  // Previous hsync
	logic        en_reg;    // Enable, active high internally
	logic [17:0] db_reg;    // Data sample

	// Default polarity is active low for all three
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg) begin
			vs_reg   <= 1'b0;
			vs_d_reg <= 1'b0;
			hs_reg   <= 1'b0;
			hs_d_reg <= 1'b0;
			en_reg   <= 1'b0;
			db_reg   <= 18'h00000;
		end else begin
			vs_reg   <= !(i_vsync ^ l_spol[2]);
			vs_d_reg <= vs_reg;
			hs_reg   <= !(i_hsync ^ l_spol[1]);
			hs_d_reg <= hs_reg;
			en_reg   <= !(i_enable ^ l_spol[0]);
			db_reg   <= i_data;
		end
	end

	logic frame_start;  // Vsync asserting edge, a pin fall at default sense
	logic line_start;   // Hsync asserting edge, a pin fall at default sense
	logic write_ok;     // RGB path owns the RAM
	logic take;         // Transfer accepted this cycle
	assign frame_start = vs_reg && !vs_d_reg;
	assign line_start  = hs_reg && !hs_d_reg;
	// Path select 0 leaves the bus ignored
	// Host keeps enable off while it owns RAM
	assign write_ok = l_path && l_rgb && l_fast &&
		l_width != `RVI_WRES;
	assign take = en_reg && write_ok;

	////////////////////////////////////////////////////////////////////
	// Pixel assembly

	logic     pix_valid;  // Pixel complete
	rvi_pix_t pix_data;   // Pixel value

	rvi_pixel_pack u_pack (
		.i_clk   (dot_clk),
		.i_rst   (rst_l_reg),
		.i_frame (frame_start),
		.i_take  (take),
		.i_width (l_width),
		.i_data  (db_reg),
		.o_valid (pix_valid),
		.o_pixel (pix_data)
	);

	////////////////////////////////////////////////////////////////////
	// RAM address counter and write port

	rvi_addr_t addr_reg;  // Next write address
	// Reload on every frame; a pixel in flight still uses the old
	// count, so a frame boundary never shifts the new frame
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg) begin
			addr_reg <= 17'h00000;
		end else if (frame_start) begin
			addr_reg <= l_addr;
		end else if (pix_valid) begin
			addr_reg <= addr_reg + 17'h00001;
		end
	end

	// Write strobe and data from flops
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg) begin
			o_ram_we    <= 1'b0;
			o_ram_addr  <= 17'h00000;
			o_ram_wdata <= 18'h00000;
		end else begin
			o_ram_we <= pix_valid;
			if (pix_valid) begin
				o_ram_addr  <= addr_reg;
				o_ram_wdata <= pix_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frame sequencing and gate scan, all on the dot clock

	rvi_frame_t state_reg;   // Porch / active state
	rvi_line_t  gate_reg;    // Lines driven this frame
	rvi_line_t  lines_full;  // Programmed line count
	rvi_line_t  lines;       // Line count, clamped
	logic       gate_fire;   // A gate clock is due
	logic       frame_end;   // Last line has been started
	assign lines_full = 10'({4'h0, l_nl} + 10'h001) << `RVI_NL_SHIFT;
	// Clamp to the panel height
	assign lines = (lines_full > `RVI_MAX_LINES) ? `RVI_MAX_LINES :
		lines_full;
	// First line starts with the first enable after the back porch
	// The source supplies those porches
	assign gate_fire = (state_reg == RVI_BACK && en_reg) ||
		(state_reg == RVI_ACTIVE && line_start);
	assign frame_end = gate_fire && gate_reg == lines - 10'h001;

	// Front porch holds until vsync; in RGB mode vsync restarts from any state
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg || !l_rgb) begin
			state_reg <= RVI_FRONT;
		end else if (frame_start) begin
			state_reg <= RVI_BACK;
		end else begin
			case (state_reg)
				RVI_FRONT: begin
					state_reg <= RVI_FRONT;
				end
				RVI_BACK: begin
					if (frame_end) begin
						state_reg <= RVI_FRONT;
					end else if (en_reg) begin
						state_reg <= RVI_ACTIVE;
					end
				end
				RVI_ACTIVE: begin
					if (frame_end) begin
						state_reg <= RVI_FRONT;
					end
				end
				default: begin
					state_reg <= RVI_FRONT;
				end
			endcase
		end
	end

	// Gate clocks, exactly the driven line count per frame
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg || frame_start) begin
			gate_reg     <= 10'h000;
			o_gate_pulse <= 1'b0;
			o_gate_line  <= 10'h000;
		end else begin
			o_gate_pulse <= gate_fire;
			if (gate_fire) begin
				o_gate_line <= gate_reg;
				gate_reg    <= gate_reg + 10'h001;
			end
		end
	end

	// Base image from first line, fixed RAM rows
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg) begin
			o_base_row  <= `RVI_BASE_BEGIN;
			o_base_show <= 1'b0;
		end else if (gate_fire) begin
			o_base_row  <= `RVI_BASE_BEGIN + gate_reg[8:0];
			o_base_show <= l_base && gate_reg[8:0] <= `RVI_BASE_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status back to the system domain

	logic done_tgl_reg;  // Flips once per finished frame
	logic act_reg;       // Frame in progress, link side
	always_ff @(posedge dot_clk) begin
		if (rst_l_reg) begin
			done_tgl_reg <= 1'b0;
			act_reg      <= 1'b0;
		end else begin
			if (frame_end) begin
				done_tgl_reg <= !done_tgl_reg;
			end
			act_reg <= state_reg != RVI_FRONT;
		end
	end

	logic [1:0] st_sys;    // Toggle and activity, system side
	logic       tgl_d_reg; // Previous toggle, system side
	rvi_sync2 #(
		.WIDTH (2)
	) u_st_sync (
		.i_clk (i_sys_clk),
		.i_d   ({done_tgl_reg, act_reg}),
		.o_q   (st_sys)
	);

	// Toggle edge becomes one system-clock pulse
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tgl_d_reg     <= 1'b0;
			o_frame_pulse <= 1'b0;
			o_rgb_active  <= 1'b0;
		end else begin
			tgl_d_reg     <= st_sys[1];
			o_frame_pulse <= st_sys[1] ^ tgl_d_reg;
			o_rgb_active  <= st_sys[0];
		end
	end
	// Index and ordering of setup are the host's care
	// Partial windows are kept apart by software
endmodule : rvi_rgb_ingest
`default_nettype wire

// >>> rtl/rvi_defs.svh
// Behaviour
// - Software inverts sync, enable, dot clock polarity
// - Write pixels only while enable active low
// - Width 10 takes six upper data lines
// - Six-bit pixel is three transfers, whole pixels
// - Sub-transfer counter resets on vsync fall
// - Width 01 takes sixteen-bit pixels
// - Width 00 takes eighteen-bit pixels
// - Configuration arrives only by system side
// - No partial or scroll in RGB mode
// - Panel timing derives from dot clock
// - Stay in front porch until vsync
// - Address counter reloads on vsync fall
// - Base image fixed range, lines up to 320
// - Gate scan clocks for driven line count
// - Two-bit width select, 11 reserved
`ifndef RVI_DEFS_SVH
`define RVI_DEFS_SVH

`define RVI_W18        2'h0
`define RVI_W16        2'h1
`define RVI_W6         2'h2
`define RVI_WRES       2'h3
`define RVI_DCS_RGB    2'h1
`define RVI_SUB_FIRST  2'h0
`define RVI_SUB_SECOND 2'h1
`define RVI_SUB_THIRD  2'h2
`define RVI_NL_SHIFT   3
`define RVI_MAX_LINES  10'h140
`define RVI_BASE_BEGIN 9'h000
`define RVI_BASE_LAST  9'h13f

`endif

// >>> rtl/rvi_pkg.sv
`default_nettype none
package rvi_pkg;
	typedef logic [1:0]  rvi_width_t;  // Port width select code
	typedef logic [16:0] rvi_addr_t;   // RAM word address
	typedef logic [17:0] rvi_pix_t;    // Stored pixel, 6:6:6
	typedef logic [9:0]  rvi_line_t;   // Gate line counter
	typedef enum logic [1:0] {
		RVI_FRONT,
		RVI_BACK,
		RVI_ACTIVE
	} rvi_frame_t;
endpackage : rvi_pkg
`default_nettype wire

// >>> rtl/rvi_sync2.sv
`default_nettype none
module rvi_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,  // Destination clock
	input  wire logic [WIDTH-1:0] i_d,    // Level from other domain
	output logic      [WIDTH-1:0] o_q     // Synchronised level
);
	logic [WIDTH-1:0] meta_reg;  // First stage, read only by second

	// Two-flop crossing for levels and quasi-static words
	always_ff @(posedge i_clk) begin
		meta_reg <= i_d;
		o_q      <= meta_reg;
	end
endmodule : rvi_sync2
`default_nettype wire

// >>> rtl/rvi_pixel_pack.sv
`include "rvi_defs.svh"
`default_nettype none
module rvi_pixel_pack (
	input  wire logic          i_clk,    // Dot clock domain
	input  wire logic          i_rst,    // Synchronous, dot domain
	input  wire logic          i_frame,  // Vsync asserting edge seen
	input  wire logic          i_take,   // One bus transfer to take
	input  wire rvi_pkg::rvi_width_t i_width,  // Width select
	input  wire logic [17:0]   i_data,   // Sampled data bus
	output logic               o_valid,  // Pixel ready, one cycle
	output rvi_pkg::rvi_pix_t  o_pixel   // Assembled 18-bit pixel
);
	import rvi_pkg::*;

	logic [1:0] sub_reg;  // Which colour of a six-bit pixel is next
	logic [5:0] red_reg;  // Held red component
	logic [5:0] grn_reg;  // Held green component

	////////////////////////////////////////////////////////////////////
	// Sub-transfer counter; frame start wins over a transfer
	always_ff @(posedge i_clk) begin
		if (i_rst || i_frame) begin
			sub_reg <= `RVI_SUB_FIRST;
		end else if (i_take && i_width == `RVI_W6) begin
			if (sub_reg == `RVI_SUB_THIRD) begin
				sub_reg <= `RVI_SUB_FIRST;
			end else begin
				sub_reg <= sub_reg + 2'h1;
			end
		end
	end

	// Hold red and green until blue completes the pixel
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			red_reg <= 6'h00;
			grn_reg <= 6'h00;
		end else if (i_take && sub_reg == `RVI_SUB_FIRST) begin
			red_reg <= i_data[17:12];
		end else if (i_take && sub_reg == `RVI_SUB_SECOND) begin
			grn_reg <= i_data[17:12];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output pixel per width mode
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_pixel <= 18'h00000;
		end else begin
			o_valid <= 1'b0;
			if (i_take && !i_frame) begin
				case (i_width)
					`RVI_W18: begin
						o_valid <= 1'b1;
						o_pixel <= i_data;
					end
					`RVI_W16: begin
						// DB9 and DB0 carry nothing here
						o_valid <= 1'b1;
						o_pixel <= {i_data[17:13], i_data[17],
							i_data[12:10], i_data[8:6],
							i_data[5:1], i_data[5]};
					end
					`RVI_W6: begin
						// Lower twelve lines ignored
						if (sub_reg == `RVI_SUB_THIRD) begin
							o_valid <= 1'b1;
							o_pixel <= {red_reg, grn_reg, i_data[17:12]};
						end
					end
					default: begin
						o_valid <= 1'b0;  // Reserved code
					end
				endcase
			end
		end
	end
endmodule : rvi_pixel_pack
`default_nettype wire

// >>> test/rvi_rgb_ingest_chk.sv
`default_nettype none
module rvi_rgb_ingest_chk (
	input wire logic               i_sys_clk,              // Sys clock
	input wire logic               i_rst,                  // Sync reset
	input wire logic               i_dot_clk,              // Dot clock
	input wire logic               i_enable,               // Enable pin
	input wire logic               i_enable_polarity,      // Enable sense
	input wire logic               i_dot_clock_polarity,   // Dot edge sense
	input wire logic               i_ram_path_select,      // RAM owner
	input wire rvi_pkg::rvi_width_t i_rgb_width_select,    // Port width
	input wire logic [1:0]         i_display_clock_source, // Display mode
	input wire logic               i_partial_one_on,       // Partial 1 enable
	input wire logic               o_ram_we,               // RAM write
	input wire logic               o_gate_pulse,           // Gate clock
	input wire rvi_pkg::rvi_line_t o_gate_line,            // Gate line
	input wire logic [8:0]         o_base_row,             // Base row
	input wire logic               o_frame_pulse,          // Frame done
	input wire logic               o_partial_one_show,     // Partial 1 shown
	input wire logic               o_scroll_allow,         // Scroll permitted
	input wire logic               o_width_reserved        // Width invalid
);
	import rvi_pkg::*;
	logic [1:0] settle_reg;                                        // Sys cycles since reset
	wire logic  dot_eff = i_dot_clk ^ i_dot_clock_polarity;        // Sampling dot edge
	wire logic  en_act  = (i_enable == i_enable_polarity);         // Enable pin asserted
	////////////////////////////////////////////////
	// Mapping checks wait out the config pipe
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			settle_reg <= 2'h0;
		end else if (settle_reg != 2'h3) begin
			settle_reg <= settle_reg + 2'h1;
		end
	end
	////////////////////////////////////////////////
	chk_we_enable: assert property (@(posedge dot_eff) disable iff (i_rst)
		o_ram_we |-> $past(en_act, 3)) else $error("write without enable");
	chk_six_spacing: assert property (@(posedge dot_eff) disable iff (i_rst)
		o_ram_we && i_rgb_width_select == 2'h2 |=> !o_ram_we ##1 !o_ram_we)
		else $error("six-bit pixels too close");
	chk_path_idle: assert property (@(posedge dot_eff) disable iff (i_rst)
		(!i_ram_path_select) [*8] |-> !o_ram_we) else $error("write while path released");
	chk_dot_mode: assert property (@(posedge dot_eff) disable iff (i_rst)
		(i_display_clock_source != 2'h1) [*8] |-> !o_ram_we) else $error("write outside RGB mode");
	chk_gate_single: assert property (@(posedge dot_eff) disable iff (i_rst)
		o_gate_pulse |=> !o_gate_pulse) else $error("gate pulse too long");
	chk_base_follow: assert property (@(posedge dot_eff) disable iff (i_rst)
		o_gate_pulse |=> {1'b0, o_base_row} == $past(o_gate_line))
		else $error("base row off gate line");
	chk_frame_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_frame_pulse |=> !o_frame_pulse) else $error("frame pulse too long");
	chk_scroll_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		settle_reg == 2'h3 |-> o_scroll_allow == ($past(i_display_clock_source, 2) != 2'h1))
		else $error("scroll permit wrong");
	chk_partial_mask: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		settle_reg == 2'h3 |-> o_partial_one_show ==
		($past(i_partial_one_on, 2) && $past(i_display_clock_source, 2) != 2'h1))
		else $error("partial shown in RGB mode");
	chk_width_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		settle_reg == 2'h3 |-> o_width_reserved == ($past(i_rgb_width_select, 2) == 2'h3))
		else $error("reserved width flag wrong");
	cov_six_write: cover property (@(posedge dot_eff) o_ram_we && i_rgb_width_select == 2'h2);
	cov_gate: cover property (@(posedge dot_eff) o_gate_pulse);
	cov_frame: cover property (@(posedge i_sys_clk) o_frame_pulse);
endmodule : rvi_rgb_ingest_chk

bind rvi_rgb_ingest rvi_rgb_ingest_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_dot_clk(i_dot_clk), .i_enable(i_enable),
	.i_enable_polarity(i_enable_polarity), .i_dot_clock_polarity(i_dot_clock_polarity),
	.i_ram_path_select(i_ram_path_select), .i_rgb_width_select(i_rgb_width_select),
	.i_display_clock_source(i_display_clock_source), .i_partial_one_on(i_partial_one_on),
	.o_ram_we(o_ram_we), .o_gate_pulse(o_gate_pulse), .o_gate_line(o_gate_line),
	.o_base_row(o_base_row), .o_frame_pulse(o_frame_pulse),
	.o_partial_one_show(o_partial_one_show), .o_scroll_allow(o_scroll_allow),
	.o_width_reserved(o_width_reserved)
);
`default_nettype wire

// >>> test/rvi_video_src.sv
`default_nettype none
module rvi_video_src (
	input  wire logic [3:0] i_polarity,  // Sense: vsync, hsync, enable, dot
	output logic            o_dot_clk,   // Dot clock
	output logic            o_vsync,     // Frame sync pin
	output logic            o_hsync,     // Line sync pin
	output logic            o_enable,    // Data enable pin
	output logic [17:0]     o_data       // Pixel bus
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////
	// Free-running dot clock, phase unrelated to sys
	initial begin
		o_dot_clk = 1'b0;
		#1.7;
		forever #3 o_dot_clk = ~o_dot_clk;
	end
	// Pins start idle under the reset-time sense
	initial begin
		o_vsync = 1'b1;
		o_hsync = 1'b1;
		o_enable = 1'b1;
		o_data = 18'h0;
	end
	////////////////////////////////////////////////
	// Moves just after the sampling edge
	task automatic step();
		if (i_polarity[0]) @(negedge o_dot_clk);
		else @(posedge o_dot_clk);
		#1;
	endtask : step
	// Asserted pin is low unless its sense bit is set
	task automatic drive(input logic v, input logic h, input logic e);
		o_vsync = ~(v ^ i_polarity[3]);
		o_hsync = ~(h ^ i_polarity[2]);
		o_enable = ~(e ^ i_polarity[1]);
		if (!e) o_data = ~o_data; // Idle bus flips
	endtask : drive
	task automatic idle();
		drive(1'b0, 1'b0, 1'b0);
		step();
	endtask : idle
	// Eight lines of per words, counting up from seed
	task automatic frame(input int per, input logic [17:0] seed);
		logic [17:0] word;
		word = seed;
		drive(1'b1, 1'b0, 1'b0);
		repeat (2) step();
		drive(1'b0, 1'b0, 1'b0);
		repeat (3) step();
		for (int l = 0; l < 8; l++) begin
			drive(1'b0, 1'b1, 1'b0);
			step();
			drive(1'b0, 1'b0, 1'b0);
			step();
			for (int p = 0; p < per; p++) begin // Caller picks whole pixels or not
				o_data = word;
				word = word + 18'h1;
				drive(1'b0, 1'b0, 1'b1);
				step();
			end
			drive(1'b0, 1'b0, 1'b0);
			repeat (2) step();
		end
		drive(1'b0, 1'b1, 1'b0); // Stray line sync in front porch
		step();
		drive(1'b0, 1'b0, 1'b0);
		repeat (3) step();
	endtask : frame
endmodule : rvi_video_src
`default_nettype wire

// >>> test/rvi_rgb_ingest_tb_top.sv
`default_nettype none
module rvi_rgb_ingest_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rvi_pkg::*;
	logic        sys_clk = 1'b0;     // 100 MHz system clock
	logic        rst     = 1'b1;     // Sync reset
	logic [3:0]  pol     = 4'h0;     // Sense bits: vsync, hsync, enable, dot
	logic        path    = 1'b1;     // RAM owned by RGB port
	rvi_width_t  width   = 2'h0;     // Port width code
	rvi_addr_t   start   = 17'h00100; // Frame base address
	logic [1:0]  dcs     = 2'h1;     // Display clock source
	wire logic   dck, vs, hs, en;    // Link pins
	wire logic [17:0] bus;           // Pixel bus
	logic        we, gp, fp, act, p1s, scroll, panel, wres; // Observed flags
	rvi_addr_t   waddr;              // Write address
	rvi_pix_t    wdata;              // Write data
	logic [34:0] exp_q [$];          // Expected {address, pixel}
	int          miscompares = 0;
	int          checked = 0;
	int          gates, frames;      // Pulses seen in the current frame
	int          cyc = 0;            // Timeout counter
	wire logic   dot_eff = dck ^ pol[0]; // Edge the block samples on
	////////////////////////////////////////////////
	always #5 sys_clk = ~sys_clk;
	rvi_video_src vid (.i_polarity(pol), .o_dot_clk(dck), .o_vsync(vs), .o_hsync(hs),
		.o_enable(en), .o_data(bus));
	// Fast write, 8 lines, all images on
	rvi_rgb_ingest DUT (
		.i_sys_clk(sys_clk), .i_rst(rst), .i_dot_clk(dck), .i_vsync(vs), .i_hsync(hs),
		.i_enable(en), .i_data(bus), .i_vsync_polarity(pol[3]), .i_hsync_polarity(pol[2]),
		.i_enable_polarity(pol[1]), .i_dot_clock_polarity(pol[0]), .i_ram_path_select(path),
		.i_rgb_width_select(width), .i_fast_ram_write(1'b1), .i_ram_start_address(start),
		.i_driven_line_count(6'h00), .i_display_clock_source(dcs), .i_base_image_on(1'b1),
		.i_partial_one_on(1'b1), .i_partial_two_on(1'b1), .o_ram_we(we), .o_ram_addr(waddr),
		.o_ram_wdata(wdata), .o_gate_pulse(gp), .o_gate_line(), .o_base_row(), .o_base_show(),
		.o_frame_pulse(fp), .o_rgb_active(act), .o_partial_one_show(p1s),
		.o_partial_two_show(), .o_scroll_allow(scroll), .o_panel_from_dot(panel),
		.o_width_reserved(wres)
	);
	////////////////////////////////////////////////
	task automatic check(input logic [34:0] got, input logic [34:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// Writes matched in order against the queue
	always @(posedge dot_eff) begin
		if (we === 1'b1) begin
			if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected write");
			else check({waddr, wdata}, exp_q.pop_front(), "RAM write");
		end
		if (gp === 1'b1) gates++;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (fp === 1'b1) frames++;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	////////////////////////////////////////////////
	// Path dropped first, handed back last
	task automatic cfg(input logic [3:0] p, input rvi_width_t w, input rvi_addr_t a,
		input logic [1:0] d, input logic pa);
		@(posedge sys_clk);
		#1 path = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 pol = p;
		width = w;
		start = a;
		dcs = d;
		vid.idle();
		repeat (4) @(posedge sys_clk);
		#1 path = pa;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : cfg
	// One frame; writes predicted from words sent
	task automatic run(input int per, input logic [17:0] seed, input bit full);
		logic [17:0] w [$];
		logic [17:0] p;
		int n = 0;
		for (int k = 0; k < 8 * per; k++) w.push_back(seed + 18'(k));
		while (full && w.size() >= ((width == 2'h2) ? 3 : 1)) begin
			p = w.pop_front();
			if (width == 2'h1) p = {p[17:13], p[17], p[12:10], p[8:6], p[5:1], p[5]};
			if (width == 2'h2) begin
				p = {p[17:12], w[0][17:12], w[1][17:12]};
				void'(w.pop_front());
				void'(w.pop_front());
			end
			exp_q.push_back({start + 17'(n), p});
			n++;
		end
		gates = 0;
		frames = 0;
		vid.frame(per, seed);
		repeat (12) @(posedge sys_clk);
		#1 check(35'(exp_q.size()), 35'h0, "writes missing");
		if (full) begin
			check(35'(gates), 35'h8, "gate lines");
			check(35'(frames), 35'h1, "frames");
			check(act, 1'b0, "front porch");
		end
	endtask : run
	////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 check(scroll, 1'b0, "scroll in RGB mode");
		check(p1s, 1'b0, "partial in RGB mode");
		check(panel, 1'b1, "panel timing source");
		run(2, 18'h2a5c3, 1'b1);
		cfg(4'h0, 2'h1, 17'h01234, 2'h1, 1'b1);
		run(2, 18'h1f0e1, 1'b1);
		cfg(4'h0, 2'h2, 17'h00040, 2'h1, 1'b1);
		run(4, 18'h3c0c0, 1'b1);
		run(3, 18'h05555, 1'b1);
		cfg(4'hf, 2'h0, 17'h00777, 2'h1, 1'b1);
		run(3, 18'h12345, 1'b1);
		cfg(4'h0, 2'h0, 17'h00000, 2'h1, 1'b0);
		run(2, 18'h00abc, 1'b0);
		cfg(4'h0, 2'h3, 17'h00000, 2'h1, 1'b1);
		check(wres, 1'b1, "reserved width");
		run(2, 18'h0f0f0, 1'b0);
		cfg(4'h0, 2'h0, 17'h00000, 2'h0, 1'b1);
		check(scroll, 1'b1, "scroll in internal mode");
		check(p1s, 1'b1, "partial in internal mode");
		check(panel, 1'b0, "internal timing");
		run(2, 18'h33333, 1'b0);
		complete_run();
	end
endmodule : rvi_rgb_ingest_tb_top
`default_nettype wire
